// [hdl/flash_boot_pkg.sv]
// Overview of operation
// - Interrupts are unusable in rewrite mode, so the block holds them back and software must not count on them.
// - A running watchdog is held cleared, one cycle late, while a program or erase operation runs, but not while chip reset is asserted.
// - An asserted chip reset takes effect at all times, rewrite and program or erase included.
// - The mode-select pin is sampled as reset is released, and a high level selects boot mode.
// - In boot mode the program counter is loaded from the boot ROM vector, low byte first, then high byte.
// - The level of the mode-select pin alone decides the flash operating mode after reset.
package flash_boot_pkg;

  // ----------------------------------------------------------------------
  // vector locations and mode encoding
  // ----------------------------------------------------------------------
  localparam logic [15:0] VEC_LO_ADDR    = 16'hFFFC;
  localparam logic [15:0] VEC_HI_ADDR    = 16'hFFFD;
  localparam logic [15:0] PC_RESET_VALUE = 16'h0000;
  localparam logic        MODE_BOOT      = 1'b1;

  // ----------------------------------------------------------------------
  // vector read request to the memory
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        rd;         // read strobe, data returned in same cycle
    logic        boot_rom;   // 1 = boot rom space, 0 = user program area
    logic [15:0] addr;       // byte address
  } mem_req_type;

  localparam mem_req_type MEM_REQ_IDLE = '{rd: 1'b0, boot_rom: 1'b0,
                                           addr: 16'h0000};

endpackage

// [hdl/flash_rewrite_boot_control.sv]
`timescale 1ns/100ps
module flash_rewrite_boot_control
(
  input  wire logic                       clk,             // 50 MHz clock
  input  wire logic                       rst,             // sync reset
  input  wire logic                       mode_select_pin, // async pin
  input  wire logic                       rewrite_mode_en, // rewrite on
  input  wire logic                       prog_erase_busy, // op running
  input  wire logic                       wdt_running,     // wdt counts
  input  wire logic                       irq_req,         // core irq in
  input  wire logic [7:0]                 mem_rdata,       // vector byte
  output flash_boot_pkg::mem_req_type     mem_req_ff,      // vector read
  output logic [15:0]                     pc_ff,           // start pc
  output logic                            pc_valid_ff,     // pc loaded
  output logic                            core_reset_ff,   // hold cpu
  output logic                            boot_mode_ff,    // boot mode
  output logic                            irq_out_ff,      // irq to cpu
  output logic                            flash_block_ff,  // no array rd
  output logic                            wdt_clear_ff     // clear wdt
);

  typedef enum logic [2:0]
  {
    S_RESET  = 3'b000,
    S_SAMPLE = 3'b001,
    S_RD_LO  = 3'b010,
    S_RD_HI  = 3'b011,
    S_RUN    = 3'b100
  } state_type;

  state_type                   state_ff;
  state_type                   nxt_state;
  logic                        mode_meta_ff;
  logic                        mode_sync_ff;
  flash_boot_pkg::mem_req_type nxt_mem_req;
  logic [15:0]                 nxt_pc;
  logic                        nxt_pc_valid;
  logic                        nxt_core_reset;
  logic                        nxt_boot_mode;
  logic                        nxt_irq_out;
  logic                        nxt_flash_block;
  logic                        nxt_wdt_clear;

  // ----------------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------------
  // left out of reset on purpose so the pin is settled at release
  always_ff @(posedge clk)
  begin
    mode_meta_ff <= mode_select_pin;
    mode_sync_ff <= mode_meta_ff;
  end

  // ----------------------------------------------------------------------
  // boot sequence: sample pin, read vector, release core
  // ----------------------------------------------------------------------
  // memory answers combinationally in the cycle the strobe is shown
  always_comb
  begin
    nxt_state     = state_ff;
    nxt_mem_req   = flash_boot_pkg::MEM_REQ_IDLE;
    nxt_pc        = pc_ff;
    nxt_pc_valid  = pc_valid_ff;
    nxt_boot_mode = boot_mode_ff;
    case (state_ff)
      S_RESET:
      begin
        nxt_state = S_SAMPLE;
      end
      S_SAMPLE:
      begin
        nxt_boot_mode        = (mode_sync_ff == flash_boot_pkg::MODE_BOOT);
        nxt_mem_req.rd       = 1'b1;
        nxt_mem_req.boot_rom = nxt_boot_mode;
        nxt_mem_req.addr     = flash_boot_pkg::VEC_LO_ADDR;
        nxt_state            = S_RD_LO;
      end
      S_RD_LO:
      begin
        nxt_pc[7:0]          = mem_rdata;
        nxt_mem_req.rd       = 1'b1;
        nxt_mem_req.boot_rom = boot_mode_ff;
        nxt_mem_req.addr     = flash_boot_pkg::VEC_HI_ADDR;
        nxt_state            = S_RD_HI;
      end
      S_RD_HI:
      begin
        nxt_pc[15:8] = mem_rdata;
        nxt_pc_valid = 1'b1;
        nxt_state    = S_RUN;
      end
      S_RUN:
      begin
        nxt_state = S_RUN;
      end
      default:
      begin
        nxt_state = S_RESET;
      end
    endcase
    nxt_core_reset = (nxt_state != S_RUN);
  end

  // ----------------------------------------------------------------------
  // rewrite-mode guards
  // ----------------------------------------------------------------------
  // vector fetches would hit the array, so interrupts are simply dropped
  always_comb
  begin
    nxt_irq_out     = irq_req && !rewrite_mode_en && (state_ff == S_RUN);
    nxt_flash_block = rewrite_mode_en;
    nxt_wdt_clear   = prog_erase_busy && wdt_running;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // reset has priority over every rewrite or erase activity
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff       <= S_RESET;
      mem_req_ff     <= flash_boot_pkg::MEM_REQ_IDLE;
      pc_ff          <= flash_boot_pkg::PC_RESET_VALUE;
      pc_valid_ff    <= 1'b0;
      core_reset_ff  <= 1'b1;
      boot_mode_ff   <= 1'b0;
      irq_out_ff     <= 1'b0;
      flash_block_ff <= 1'b0;
      wdt_clear_ff   <= 1'b0;
    end
    else
    begin
      state_ff       <= nxt_state;
      mem_req_ff     <= nxt_mem_req;
      pc_ff          <= nxt_pc;
      pc_valid_ff    <= nxt_pc_valid;
      core_reset_ff  <= nxt_core_reset;
      boot_mode_ff   <= nxt_boot_mode;
      irq_out_ff     <= nxt_irq_out;
      flash_block_ff <= nxt_flash_block;
      wdt_clear_ff   <= nxt_wdt_clear;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence vec_lo_seq;
    mem_req_ff.rd && (mem_req_ff.addr == flash_boot_pkg::VEC_LO_ADDR);
  endsequence

  sequence vec_hi_seq;
    mem_req_ff.rd && (mem_req_ff.addr == flash_boot_pkg::VEC_HI_ADDR);
  endsequence

  chk_irq_blocked: assert property (@(posedge clk) disable iff (rst)
    rewrite_mode_en |=> !irq_out_ff)
    else $error("interrupt passed during rewrite mode");

  chk_fetch_block: assert property (@(posedge clk) disable iff (rst)
    rewrite_mode_en |=> flash_block_ff)
    else $error("array fetch not blocked in rewrite mode");

  chk_wdt_held: assert property (@(posedge clk) disable iff (rst)
    (prog_erase_busy && wdt_running) |=> wdt_clear_ff)
    else $error("watchdog not cleared during program or erase");

  chk_reset_wins: assert property (@(posedge clk)
    rst |=> core_reset_ff && !pc_valid_ff && !mem_req_ff.rd && !irq_out_ff)
    else $error("reset did not take effect");

  chk_pin_sample: assert property (@(posedge clk) disable iff (rst)
    (state_ff == S_SAMPLE) |=> (boot_mode_ff == $past(mode_sync_ff)))
    else $error("boot mode differs from sampled pin");

  chk_vector_order: assert property (@(posedge clk) disable iff (rst)
    (state_ff == S_SAMPLE) |=> vec_lo_seq ##1 vec_hi_seq ##1 pc_valid_ff)
    else $error("vector read order wrong");

  chk_pc_value: assert property (@(posedge clk) disable iff (rst)
    $rose(pc_valid_ff) |-> pc_ff == {$past(mem_rdata), $past(mem_rdata, 2)})
    else $error("program counter not loaded from vector");

  chk_vector_space: assert property (@(posedge clk) disable iff (rst)
    mem_req_ff.rd |-> (mem_req_ff.boot_rom == boot_mode_ff))
    else $error("vector read from wrong memory space");

  chk_user_start: assert property (@(posedge clk) disable iff (rst)
    (state_ff == S_SAMPLE && !mode_sync_ff) |=> !mem_req_ff.boot_rom)
    else $error("low pin did not select user area");

  chk_start_time: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> ##4 (pc_valid_ff && !core_reset_ff))
    else $error("core not released four cycles after reset");

endmodule

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic                        clk;
  logic                        rst;
  logic                        mode_select_pin;
  logic                        rewrite_mode_en;
  logic                        prog_erase_busy;
  logic                        wdt_running;
  logic                        irq_req;
  logic [7:0]                  mem_rdata;
  logic [7:0]                  lo_byte;
  logic [7:0]                  hi_byte;
  flash_boot_pkg::mem_req_type mem_req_ff;
  logic [15:0]                 pc_ff;
  logic                        pc_valid_ff;
  logic                        core_reset_ff;
  logic                        boot_mode_ff;
  logic                        irq_out_ff;
  logic                        flash_block_ff;
  logic                        wdt_clear_ff;
  int                          n_mismatch;
  int                          tests_run;
  logic [15:0]                 addr_q[$];
  logic                        rom_q[$];

  flash_rewrite_boot_control DUT (.clk(clk), .rst(rst),
    .mode_select_pin(mode_select_pin), .rewrite_mode_en(rewrite_mode_en),
    .prog_erase_busy(prog_erase_busy), .wdt_running(wdt_running),
    .irq_req(irq_req), .mem_rdata(mem_rdata), .mem_req_ff(mem_req_ff),
    .pc_ff(pc_ff), .pc_valid_ff(pc_valid_ff), .core_reset_ff(core_reset_ff),
    .boot_mode_ff(boot_mode_ff), .irq_out_ff(irq_out_ff),
    .flash_block_ff(flash_block_ff), .wdt_clear_ff(wdt_clear_ff));

  // ----------------------------------------------------------------------
  // clock and vector memory
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // zero-latency rom; off-strobe it shows the inverse so stale reads show
  assign mem_rdata = !mem_req_ff.rd ? ~lo_byte :
    (mem_req_ff.addr == flash_boot_pkg::VEC_HI_ADDR) ? hi_byte : lo_byte;

  // ----------------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------------
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_word(input logic [15:0] got, exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // ----------------------------------------------------------------------
  // reset, boot vector fetch, late pin change
  // ----------------------------------------------------------------------
  task automatic boot(input logic pin);
    int n;
    @(negedge clk);
    rst = 1'b1;
    mode_select_pin = pin;
    lo_byte = 8'($urandom);
    hi_byte = 8'($urandom);
    addr_q.delete();
    rom_q.delete();
    repeat (12) @(negedge clk);
    cmp_flag(core_reset_ff, 1'b1, "core held in reset");
    cmp_flag(pc_valid_ff, 1'b0, "pc valid in reset");
    cmp_flag(wdt_clear_ff, 1'b0, "wdt clear in reset");
    rst = 1'b0;
    n = 0;
    while (pc_valid_ff !== 1'b1)
    begin
      @(negedge clk);
      n++;
      cmp_flag(irq_out_ff, 1'b0, "irq before run");
      if (mem_req_ff.rd === 1'b1)
      begin
        addr_q.push_back(mem_req_ff.addr);
        rom_q.push_back(mem_req_ff.boot_rom);
      end
      if (n > 20)
      begin
        n_mismatch++;
        $display("BAD %0t boot never completed", $time);
        summarize();
      end
    end
    // pad so a short fetch shows as a mismatch, not an index fault
    while (addr_q.size() < 3) addr_q.push_back(16'hFFFF);
    while (rom_q.size() < 2) rom_q.push_back(~pin);
    cmp_word(16'(n), 16'h0004, "boot latency");
    cmp_word(addr_q[0], flash_boot_pkg::VEC_LO_ADDR, "first fetch");
    cmp_word(addr_q[1], flash_boot_pkg::VEC_HI_ADDR, "second fetch");
    cmp_word(addr_q[2], 16'hFFFF, "extra fetch");
    cmp_flag(rom_q[0] & rom_q[1] | ~pin, 1'b1, "rom space high");
    cmp_flag((rom_q[0] | rom_q[1]) & ~pin, 1'b0, "rom space low");
    cmp_word(pc_ff, {hi_byte, lo_byte}, "start pc");
    cmp_flag(boot_mode_ff, pin, "boot mode");
    cmp_flag(core_reset_ff, 1'b0, "core released");
    mode_select_pin = ~pin;
    repeat (4) @(negedge clk);
    cmp_flag(boot_mode_ff, pin, "late pin change");
  endtask

  // ----------------------------------------------------------------------
  // random guard traffic against a one-cycle-late model
  // ----------------------------------------------------------------------
  task automatic guards(input int cycles);
    logic pr, pb, pw, pi;
    {pr, pb, pw, pi} = {rewrite_mode_en, prog_erase_busy, wdt_running,
                        irq_req};
    repeat (cycles)
    begin
      @(negedge clk);
      cmp_flag(flash_block_ff, pr, "flash block");
      cmp_flag(irq_out_ff, pi & ~pr, "irq gate");
      cmp_flag(wdt_clear_ff, pb & pw, "wdt clear");
      {rewrite_mode_en, prog_erase_busy, wdt_running, irq_req} =
        4'($urandom);
      {pr, pb, pw, pi} = {rewrite_mode_en, prog_erase_busy, wdt_running,
                          irq_req};
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence; second reset lands mid program with all guards on
  // ----------------------------------------------------------------------
  initial
  begin
    {rst, mode_select_pin, rewrite_mode_en} = 3'h4;
    // irq held high through the first boot so the run gate is exercised
    {prog_erase_busy, wdt_running, irq_req} = 3'h1;
    {lo_byte, hi_byte, n_mismatch, tests_run} = '0;
    void'($urandom(32'hf619c08e));
    boot(1'b1);
    guards(300);
    @(negedge clk);
    {rewrite_mode_en, prog_erase_busy, wdt_running, irq_req} = 4'hF;
    boot(1'b0);
    guards(300);
    summarize();
  end
endmodule
